/* p2cd_defs.svh */
// Timing and setting constants for the dual power-of-two clock divider
`ifndef P2CD_DEFS_SVH
`define P2CD_DEFS_SVH

// Master clock nominal frequency in kHz
`define P2CD_MOSC_KHZ 1048
// Largest divide exponent and its divisor
`define P2CD_EXP_MAX 5'd22
`define P2CD_DIV_MAX 4194304
// Exponent field width
`define P2CD_EXP_W 5
// Power-up time to active outputs, in ms
`define P2CD_PU_MS 10
// System clock in kHz
`define P2CD_CLK_KHZ 25000
// Cycles of system clock for the power-up wait
`define P2CD_PU_CYC (`P2CD_PU_MS * `P2CD_CLK_KHZ)
// Default exponents
`define P2CD_EXP_A_DEF 5'd0
`define P2CD_EXP_B_DEF 5'd0

`endif

/* p2cd_pkg.sv */
// Types for the dual power-of-two clock divider
`include "p2cd_defs.svh"
package p2cd_pkg;
  typedef logic [`P2CD_EXP_W-1:0] p2cd_exp_t;
  typedef enum logic [1:0] {
    P2CD_ST_WAIT = 2'b01,
    P2CD_ST_RUN = 2'b10
  } p2cd_state_e;
endpackage

/* p2cd_div_chan.sv */
// One gated output channel: select the master or a tap of the shared counter, force high when disabled
`timescale 1ns/1ns
`default_nettype none
module p2cd_div_chan
  import p2cd_pkg::*;
#(
  parameter p2cd_exp_t DIV_EXP = `P2CD_EXP_A_DEF
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Shared divider state
  input wire logic mosc_i,
  input wire logic [21:0] cnt_i,
  input wire logic active_i,
  // Enable, already synchronised, active low
  input wire logic enable_n_i,
  // Output
  output logic clk_o
);

  logic tap_q;
  logic tap_d;
  logic sel_w;

  // Exponent n picks counter bit n-1, which toggles each 2^(n-1) cycles
  // Split so no out-of-range index is ever elaborated for exponent 0
  if (DIV_EXP == 5'd0) begin : g_pass
    assign sel_w = mosc_i; // R3
  end else begin : g_tap
    assign sel_w = cnt_i[DIV_EXP - 5'd1]; // R12
  end
  assign tap_d = sel_w;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tap_q <= 1'b1;
    end else begin
      tap_q <= tap_d;
    end
  end

  // Gate is combinational so a disable forces high with no clock wait
  assign clk_o = (enable_n_i || !active_i) ? 1'b1 : tap_q; // R5 R6 R8 R9

endmodule // p2cd_div_chan
`default_nettype wire

/* p2cd_top.sv */
// Dual power-of-two clock divider with active-low output enables
// Summary of operation
// R1: One master clock feeds both dividers
// R2: Output equals master over two to exponent
// R3: Exponent only 0 to 22; 0 passes master
// R4: Each output set only by its exponent
// R5: Enable low drives divided square wave
// R6: Enable high forces output high immediately
// R7: Disable gates output only; dividers keep running
// R8: Disable during low phase forces high
// R9: Enable shows free-running divider state at once
// R10: Unused output enable held high by system
// R11: Outputs active within 10 ms of power
// R12: Toggle every 2^(n-1) master cycles
// Master rate arrives as a tick, two ticks per master period
// Pin enables pass two flops, so a disable lands two clocks late
// Exponents above the top setting are clamped to the slowest rate
// Outputs stay high through reset and the power-up wait
`timescale 1ns/1ns
`default_nettype none
module p2cd_top
  import p2cd_pkg::*;
#(
  parameter p2cd_exp_t DIV_EXP_A = `P2CD_EXP_A_DEF,
  parameter p2cd_exp_t DIV_EXP_B = `P2CD_EXP_B_DEF,
  parameter int unsigned PU_CYCLES = `P2CD_PU_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Master oscillator tick, one-cycle pulse at twice the master rate
  input wire logic mosc_tick_i,
  // Output enables, pins, active low
  input wire logic out_a_enable_n,
  input wire logic out_b_enable_n,
  // Divided outputs
  output logic clk_out_a,
  output logic clk_out_b,
  // Status
  output logic active_o
);

  // Settings past the top have no counter tap; clamp them to the slowest rate
  localparam p2cd_exp_t EXP_TOP = `P2CD_EXP_MAX;
  localparam bit EXP_A_OK = (DIV_EXP_A <= EXP_TOP);
  localparam bit EXP_B_OK = (DIV_EXP_B <= EXP_TOP);
  localparam p2cd_exp_t EXP_A_USE = EXP_A_OK ? DIV_EXP_A : EXP_TOP; // R3
  localparam p2cd_exp_t EXP_B_USE = EXP_B_OK ? DIV_EXP_B : EXP_TOP; // R3
  // Bit 21 is the tap of the largest exponent
  localparam int unsigned CNT_W = 22;
  // Last value of the power-up count; a zero wait still takes one cycle
  localparam int unsigned PU_LAST = (PU_CYCLES > 32'd0) ? PU_CYCLES - 32'd1 : 32'd0;

  // Enable synchronisers, one chain per channel
  logic ena_a_meta_q;
  logic ena_a_sync_q;
  logic ena_b_meta_q;
  logic ena_b_sync_q;
  logic ena_a_n_w;
  logic ena_b_n_w;

  // Master square wave and the count shared by both channels
  logic mosc_q;
  logic mosc_d;
  logic mosc_fall_w;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] cnt_inc_w;

  // Power-up sequencer; 32 bits hold the full wait at the system clock
  logic [31:0] pu_cnt_q;
  logic [31:0] pu_cnt_d;
  logic [31:0] pu_inc_w;
  p2cd_state_e state_q;
  p2cd_state_e state_d;
  logic in_wait_w;
  logic pu_done_w;
  logic go_run_w;
  logic active_w;

  // Enables come from pins: two flops before use; reset reads as disabled
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ena_a_meta_q <= 1'b1;
    end else begin
      ena_a_meta_q <= out_a_enable_n;
    end
  end

  // Second stage; the first may still be settling
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ena_a_sync_q <= 1'b1;
    end else begin
      ena_a_sync_q <= ena_a_meta_q;
    end
  end

  // Channel B chain
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ena_b_meta_q <= 1'b1;
    end else begin
      ena_b_meta_q <= out_b_enable_n;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ena_b_sync_q <= 1'b1;
    end else begin
      ena_b_sync_q <= ena_b_meta_q;
    end
  end

  // Only the second stage of each chain is read
  assign ena_a_n_w = ena_a_sync_q;
  assign ena_b_n_w = ena_b_sync_q;

  // Master square wave toggles on each tick
  assign mosc_d = mosc_tick_i ? ~mosc_q : mosc_q; // R1
  // Count steps once per master period, as the master falls
  assign mosc_fall_w = mosc_tick_i && mosc_q; // R1
  assign cnt_inc_w = cnt_q + 22'h1;
  // Enables never touch the count, so a channel resumes in phase
  assign cnt_d = mosc_fall_w ? cnt_inc_w : cnt_q; // R2 R7

  // Master phase
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mosc_q <= 1'b0;
    end else begin
      mosc_q <= mosc_d; // R1
    end
  end

  // Wraps freely; its top bit has the largest period
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 22'h0;
    end else begin
      cnt_q <= cnt_d; // R7
    end
  end

  // Power-up wait: hold outputs high until the count ends
  assign in_wait_w = (state_q == P2CD_ST_WAIT);
  assign pu_done_w = (pu_cnt_q >= PU_LAST); // R11
  assign go_run_w = in_wait_w && pu_done_w; // R11
  assign pu_inc_w = pu_cnt_q + 32'h1;
  // Count freezes once running, so it cannot wrap back into the wait
  assign pu_cnt_d = in_wait_w ? pu_inc_w : pu_cnt_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      P2CD_ST_WAIT: begin
        if (go_run_w) begin
          state_d = P2CD_ST_RUN; // R11
        end else begin
          state_d = P2CD_ST_WAIT;
        end
      end
      P2CD_ST_RUN: begin
        // No way back but reset
        state_d = P2CD_ST_RUN;
      end
      default: begin
        state_d = P2CD_ST_WAIT;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= P2CD_ST_WAIT;
    end else begin
      state_q <= state_d;
    end
  end

  // Wait count
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pu_cnt_q <= 32'h0;
    end else begin
      pu_cnt_q <= pu_cnt_d;
    end
  end

  // Status
  assign active_w = (state_q == P2CD_ST_RUN);
  assign active_o = active_w;

  // Each channel sees only its own exponent and enable
  // Channel A
  p2cd_div_chan #(
    .DIV_EXP(EXP_A_USE)
  ) u_chan_a (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .mosc_i(mosc_q),
    .cnt_i(cnt_q),
    .active_i(active_w),
    .enable_n_i(ena_a_n_w),
    .clk_o(clk_out_a)
  ); // R4

  // Channel B
  p2cd_div_chan #(
    .DIV_EXP(EXP_B_USE)
  ) u_chan_b (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .mosc_i(mosc_q),
    .cnt_i(cnt_q),
    .active_i(active_w),
    .enable_n_i(ena_b_n_w),
    .clk_o(clk_out_b)
  ); // R4

endmodule // p2cd_top
`default_nettype wire

/* p2cd_top_properties.sv */
// Port checker for the dual clock divider
`timescale 1ns/1ns
`default_nettype none
module p2cd_top_props (
  input wire logic clk_i, rst_n_i, out_a_enable_n, out_b_enable_n, clk_out_a, clk_out_b,
  input wire logic active_o
);
  // Bounds assume exponents 2 and 0 and a tick every 4 cycles
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_oa; out_a_enable_n [*3] |-> clk_out_a; endproperty
  a_oa: assert property (p_oa) else $error("a not held high");
  property p_ob; $rose(out_b_enable_n) |-> ##2 clk_out_b [*2]; endproperty
  a_ob: assert property (p_ob) else $error("b not forced high");
  property p_ha; $fell(clk_out_a) |-> ##16 clk_out_a; endproperty
  a_ha: assert property (p_ha) else $error("a half period");
  property p_hb; $fell(clk_out_b) |-> ##4 clk_out_b; endproperty
  a_hb: assert property (p_hb) else $error("b half period");
  property p_rb; (active_o && !out_b_enable_n)[*8] |-> clk_out_b != $past(clk_out_b, 4);
  endproperty
  a_rb: assert property (p_rb) else $error("b not running");
  property p_pu; !active_o |-> ##[1:14] active_o; endproperty
  a_pu: assert property (p_pu) else $error("late power-up");
  property p_ac; active_o |=> active_o; endproperty
  a_ac: assert property (p_ac) else $error("active dropped");
  property p_qt; !active_o |-> clk_out_a && clk_out_b; endproperty
  a_qt: assert property (p_qt) else $error("early output");
  c_fa: cover property ($fell(clk_out_a));
  c_fb: cover property ($fell(clk_out_b));
  c_ac: cover property ($rose(active_o));
endmodule // p2cd_top_props
bind p2cd_top p2cd_top_props p2cd_top_props_i (.*);
`default_nettype wire

/* p2cd_led_model.sv */
// LED loads counting flashes on both outputs
`timescale 1ns/1ns
`default_nettype none
module p2cd_led_model (
  input wire logic clk_i, clr_i, clk_out_a, clk_out_b,
  output var int na_o, nb_o
);
  logic a_q, b_q;
  // A flash starts where the sunk output falls
  always_ff @(posedge clk_i) begin
    a_q <= clk_out_a;
    b_q <= clk_out_b;
    na_o <= clr_i ? 0 : na_o + int'(a_q && !clk_out_a);
    nb_o <= clr_i ? 0 : nb_o + int'(b_q && !clk_out_b);
  end
endmodule // p2cd_led_model
`default_nettype wire

/* dual_pow2_clock_divider_test.sv */
// Self-checking bench for the dual clock divider
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, v) begin tests_run++; if ((v) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %0d got %0d", n, e, v); end end
module dual_pow2_clock_divider_test;
  logic clk_i = 0, rst_n_i = 0, mosc_tick_i = 0, clr_i = 1, out_a_enable_n = 1;
  logic out_b_enable_n = 1, clk_out_a, clk_out_b, active_o;
  logic [1:0] ph_q = 2'h0;
  int err_total = 0, tests_run = 0, na_o, nb_o, i;
  always #20 clk_i = ~clk_i;
  // One tick in four cycles keeps the master half period at 4
  always @(negedge clk_i) begin
    ph_q <= ph_q + 2'h1;
    mosc_tick_i <= ph_q == 2'h3;
  end
  p2cd_top #(.DIV_EXP_A(5'h02), .DIV_EXP_B(5'h00), .PU_CYCLES(10)) p2cd_top_i (.*);
  p2cd_led_model p2cd_led_model_i (.*);
  task automatic run(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic count(input int n, ea, eb);
    clr_i = 1;
    run(1);
    clr_i = 0;
    run(n);
    `CHK("flashes a", ea, na_o)
    `CHK("flashes b", eb, nb_o)
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #120000;
    err_total++;
    stop_test;
  end
  initial begin
    run(20);
    `CHK("a in reset", 1'b1, clk_out_a)
    rst_n_i = 1;
    run(14);
    `CHK("active", 1'b1, active_o)
    count(64, 0, 0);
    out_a_enable_n = 0;
    run(4);
    count(320, 10, 0);
    out_b_enable_n = 0;
    run(4);
    count(160, 5, 20);
    $display("rate test done");
    // Catch the fall so the disable lands early in the low half
    for (i = 0; i < 40 && clk_out_a !== 1'b1; i++) run(1);
    for (i = 0; i < 40 && clk_out_a !== 1'b0; i++) run(1);
    `CHK("a low before cut", 1'b0, clk_out_a)
    out_a_enable_n = 1;
    run(2);
    `CHK("a cut short", 1'b1, clk_out_a)
    out_a_enable_n = 0;
    run(3);
    count(320, 10, 40);
    out_b_enable_n = 1;
    run(3);
    `CHK("b off", 1'b1, clk_out_b)
    rst_n_i = 0;
    run(2);
    `CHK("active in reset", 1'b0, active_o)
    $display("gate test done");
    stop_test;
  end
endmodule // dual_pow2_clock_divider_test
`default_nettype wire
